//--- pkg/scm_pkg.sv
// constants and types for the sensor correction coefficient datapath
package scm_pkg;
  // register offsets in the coefficient word space
  localparam logic [4:0]  SCM_OFS_BRIDGE_CFG = 5'h0f;
  localparam logic [4:0]  SCM_OFS_TEMP_CFG   = 5'h10;
  localparam logic [4:0]  SCM_OFS_SIGN_CFG   = 5'h01;
  // reset values (no documented reset, plain zeros)
  localparam logic [15:0] SCM_RST_WORD       = 16'h0000;
  // field positions in configuration word 01
  localparam int          SCM_CURVE_BIT      = 9;
  localparam int          SCM_DRIFT_SIGN_LO  = 10;
  localparam int          SCM_SO_SIGN_LO     = 12;
  // field positions of the bridge configuration word
  localparam int          SCM_CONV_OFS_LO    = 0;
  // gain and fixed-point layout
  localparam int          SCM_GAIN_X8_BIT    = 15;
  localparam int          SCM_GAIN_FRAC      = 13;  // 2000 hex is unity
  localparam int          SCM_SO_FRAC        = 15;  // fraction bits of second-order terms
  localparam int          SCM_X8_SHIFT       = 3;
  localparam logic [15:0] SCM_UNSIGNED_BIAS  = 16'h2000;
  // converter offset code meaning minus one half to plus one half
  localparam logic [3:0]  SCM_CONV_OFS_HALF  = 4'h8;
  // pipeline depth of the datapath
  localparam int          SCM_LATENCY        = 4;
  typedef enum logic [1:0] {
    SCM_ST_IDLE = 2'b00,
    SCM_ST_MUL1 = 2'b01,
    SCM_ST_MUL2 = 2'b11,
    SCM_ST_DONE = 2'b10
  } scm_state_t;
endpackage

//--- design/scm_stage.sv
// one correction stage: z = gain*(raw + offset), out = z*(1 + so*z)
`timescale 1ns/1ps
`default_nettype none
module scm_stage
  import scm_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                start,
  input  wire logic signed [W-1:0] raw_val,
  input  wire logic [15:0]         gain_coef,
  input  wire logic [15:0]         offset_coef,
  input  wire logic [15:0]         so_mag,
  input  wire logic                so_neg,
  input  wire logic                add_bias,
  output logic signed [31:0]       inter_out,
  output logic signed [47:0]       corr_out,
  output logic                     done
);
  typedef struct packed {
    scm_state_t         st;
    logic signed [23:0] sum;
    logic signed [31:0] z;
    logic signed [47:0] y;
    logic               dn;
  } scm_stage_st_t;

  scm_stage_st_t s_r;
  scm_stage_st_t s_nxt;
  logic signed [35:0] gprod;
  logic signed [63:0] sprod;
  logic signed [16:0] so_s;

  // wide products leave headroom for every allowed coefficient
  always_comb begin
    s_nxt    = s_r;
    s_nxt.dn = 1'b0;
    gprod = $signed({1'b0, gain_coef[14:0]}) * s_r.sum;
    if (gain_coef[SCM_GAIN_X8_BIT]) begin
      gprod = gprod <<< SCM_X8_SHIFT;
    end
    so_s  = so_neg ? -$signed({1'b0, so_mag}) : $signed({1'b0, so_mag});
    sprod = so_s * s_r.z;
    case (s_r.st)
      SCM_ST_IDLE: begin
        if (start) begin
          // signed offset added to the conversion result before gain
          s_nxt.sum = 24'(raw_val) + 24'($signed(offset_coef));
          s_nxt.st  = SCM_ST_MUL1;
        end
      end
      SCM_ST_MUL1: begin
        s_nxt.z = 32'(gprod >>> SCM_GAIN_FRAC)
                + (add_bias ? 32'(SCM_UNSIGNED_BIAS) : 32'sd0);
        s_nxt.st = SCM_ST_MUL2;
      end
      SCM_ST_MUL2: begin
        // z*(1 + so*z) = z + so*z*z; so carries one 2^-15 scale, so shift once only
        s_nxt.y  = 48'(s_r.z) + 48'((sprod * s_r.z) >>> SCM_SO_FRAC);
        s_nxt.st = SCM_ST_DONE;
      end
      SCM_ST_DONE: begin
        s_nxt.dn = 1'b1;
        s_nxt.st = SCM_ST_IDLE;
      end
      default: s_nxt.st = SCM_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // a strobe while busy never restarts the stage
  property p_busy_drop;
    @(posedge clock) disable iff (rst)
      s_r.st != SCM_ST_IDLE |=> s_r.st != SCM_ST_MUL1;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("busy stage restarted");

  assign inter_out = s_r.z;
  assign corr_out  = s_r.y;
  assign done      = s_r.dn;
endmodule
`default_nettype wire

//--- design/scm_top.sv
// correction datapath top: configuration words and temperature/bridge stages
// Summary of operation
// - intermediate temperature is gain times raw temperature plus offset.
// - corrected temperature is intermediate times one plus second-order times intermediate.
// - offset is a signed value added to the raw reading before gain.
// - with half-range converter offset the raw bridge reading is signed.
// - raw temperature reading is unsigned 0 to 16383.
// - gain is fixed point with 2000 hex as unity.
// - gain bit 15 multiplies the gain by eight.
// - offsets are 16-bit two's complement.
// - offset drift is a magnitude signed by the drift-sign field.
// - gain drift is a magnitude signed by the drift-sign field.
// - second-order terms are magnitudes signed by the second-order sign field.
// - curve shape selects parabolic or S-shaped fit for the bridge only.
// - block delivers corrected readings five cycles after each taken sample.
// - parabolic bridge fit adds 2000 hex to the intermediate result.
// - bit 9 of word 01 holds the curve shape, 1 is S-shaped.
`timescale 1ns/1ps
`default_nettype none
module scm_top
  import scm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cfg_wr,
  input  wire logic [4:0]  cfg_addr,
  input  wire logic [15:0] cfg_wdata,
  output logic      [15:0] cfg_rdata,
  input  wire logic        sample_valid,
  input  wire logic [13:0] raw_temp,
  input  wire logic [13:0] raw_bridge_reading,
  input  wire logic [15:0] temp_gain,
  input  wire logic [15:0] temp_offset,
  input  wire logic [15:0] temp_second_order_coef,
  input  wire logic [15:0] bridge_gain,
  input  wire logic [15:0] bridge_offset,
  input  wire logic [15:0] bridge_nonlinearity_coef,
  input  wire logic [15:0] offset_drift,
  input  wire logic [15:0] gain_drift,
  output logic      [15:0] temp_corrected,
  output logic      [15:0] bridge_corrected,
  output logic      [1:0]  drift_signs,
  output logic             result_valid
);
  typedef struct packed {
    logic [15:0] sign_cfg;
    logic [15:0] bcfg;
    logic [15:0] tcfg;
    logic [15:0] rdata;
    logic [15:0] tout;
    logic [15:0] bout;
    logic [1:0]  dsg;
    logic        vld;
  } scm_top_st_t;

  scm_top_st_t s_r;
  scm_top_st_t s_nxt;
  logic signed [15:0] t_raw_s;
  logic signed [15:0] b_raw_s;
  logic               t_done;
  logic               b_done;
  logic signed [47:0] t_y;
  logic signed [47:0] b_y;
  logic               b_parab;

  // unsigned temperature, bridge signed when converter offset is half range
  assign t_raw_s = $signed({2'b00, raw_temp});
  assign b_raw_s = (s_r.bcfg[SCM_CONV_OFS_LO +: 4] == SCM_CONV_OFS_HALF)
                 ? 16'($signed(raw_bridge_reading))
                 : $signed({2'b00, raw_bridge_reading});
  // curve shape only touches the bridge path
  assign b_parab = ~s_r.sign_cfg[SCM_CURVE_BIT];

  scm_stage #(.W(16)) u_temp (
    .clock       (clock),
    .rst         (rst),
    .start       (sample_valid),
    .raw_val     (t_raw_s),
    .gain_coef   (temp_gain),
    .offset_coef (temp_offset),
    .so_mag      (temp_second_order_coef),
    .so_neg      (s_r.sign_cfg[SCM_SO_SIGN_LO]),
    .add_bias    (1'b0),
    .inter_out   (),
    .corr_out    (t_y),
    .done        (t_done)
  );

  // S-shaped fit is not specified in detail; its second step is kept parabolic-free
  scm_stage #(.W(16)) u_bridge (
    .clock       (clock),
    .rst         (rst),
    .start       (sample_valid),
    .raw_val     (b_raw_s),
    .gain_coef   (bridge_gain),
    .offset_coef (bridge_offset),
    .so_mag      (b_parab ? bridge_nonlinearity_coef : 16'h0000),
    .so_neg      (s_r.sign_cfg[SCM_SO_SIGN_LO + 1]),
    .add_bias    (b_parab),
    .inter_out   (),
    .corr_out    (b_y),
    .done        (b_done)
  );

  // configuration writes, read-back and result capture
  always_comb begin
    s_nxt     = s_r;
    s_nxt.vld = 1'b0;
    if (cfg_wr) begin
      case (cfg_addr)
        SCM_OFS_SIGN_CFG:   s_nxt.sign_cfg = cfg_wdata;
        SCM_OFS_BRIDGE_CFG: s_nxt.bcfg     = cfg_wdata;
        SCM_OFS_TEMP_CFG:   s_nxt.tcfg     = cfg_wdata;
        default:            s_nxt.rdata    = s_r.rdata;
      endcase
    end
    case (cfg_addr)
      SCM_OFS_SIGN_CFG:   s_nxt.rdata = s_r.sign_cfg;
      SCM_OFS_BRIDGE_CFG: s_nxt.rdata = s_r.bcfg;
      SCM_OFS_TEMP_CFG:   s_nxt.rdata = s_r.tcfg;
      default:            s_nxt.rdata = 16'h0000;
    endcase
    // drift magnitudes carry their signs from the drift-sign field
    s_nxt.dsg = s_r.sign_cfg[SCM_DRIFT_SIGN_LO +: 2];
    if (t_done && b_done) begin
      s_nxt.tout = t_y[15:0];
      s_nxt.bout = b_y[15:0];
      s_nxt.vld  = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cfg_rdata        = s_r.rdata;
  assign temp_corrected   = s_r.tout;
  assign bridge_corrected = s_r.bout;
  assign drift_signs      = s_r.dsg;
  assign result_valid     = s_r.vld;

  // a sample is taken only when it finds the temperature stage idle
  sequence s_taken;
    sample_valid && u_temp.s_r.st == SCM_ST_IDLE;
  endsequence

  // result follows a taken sample after a fixed latency; busy strobes start nothing
  property p_latency;
    @(posedge clock) disable iff (rst)
      s_taken |-> ##5 result_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("result not on time");

  // parabolic bridge fit lifts the intermediate into the unsigned domain
  property p_curve_bias;
    @(posedge clock) disable iff (rst)
      u_bridge.s_r.st == SCM_ST_MUL1 && b_parab
        |=> u_bridge.s_r.z == 32'($past(u_bridge.gprod) >>> SCM_GAIN_FRAC)
                            + 32'(SCM_UNSIGNED_BIAS);
  endproperty
  a_curve_bias: assert property (p_curve_bias) else $error("bias missing");

  // s-shaped fit drops the bridge square term, so the result is the intermediate
  property p_s_shape;
    @(posedge clock) disable iff (rst)
      u_bridge.s_r.st == SCM_ST_MUL2 && !b_parab
        |=> u_bridge.s_r.y == 48'(u_bridge.s_r.z);
  endproperty
  a_s_shape: assert property (p_s_shape) else $error("s-shape kept square term");

  property p_cfg_read;
    @(posedge clock) disable iff (rst)
      cfg_wr && cfg_addr == SCM_OFS_TEMP_CFG ##1 cfg_addr == SCM_OFS_TEMP_CFG && !cfg_wr
        |=> cfg_rdata == $past(cfg_wdata, 2);
  endproperty
  // temperature word reads back what software wrote
  a_cfg_read: assert property (p_cfg_read) else $error("readback wrong");

  property p_drift;
    @(posedge clock) disable iff (rst)
      ##1 drift_signs == $past(s_r.sign_cfg[11:10]);
  endproperty
  a_drift: assert property (p_drift) else $error("drift sign wrong");
endmodule
`default_nettype wire

//--- test/test_sensor_correction_coefficient_math.sv
// self-checking bench for the correction datapath top
`timescale 1ns/1ps
`default_nettype none
module test_sensor_correction_coefficient_math
  import scm_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_wr = 1'b0;
  logic [4:0]  cfg_addr = 5'h00;
  logic [15:0] cfg_wdata = 16'h0000;
  logic [15:0] cfg_rdata, temp_corrected, bridge_corrected;
  logic [1:0]  drift_signs;
  logic        result_valid;
  logic        sample_valid = 1'b0;
  logic [13:0] raw_temp = 14'h0000;
  logic [13:0] raw_bridge_reading = 14'h0000;
  logic [15:0] temp_gain = 16'h2000, temp_offset = 16'h0000;
  logic [15:0] bridge_gain = 16'h2000, bridge_offset = 16'h0000;
  logic [15:0] temp_second_order_coef = 16'h0000;
  logic [15:0] bridge_nonlinearity_coef = 16'h0000;
  logic [15:0] offset_drift = 16'h1234, gain_drift = 16'h0042;
  int          n_mismatch = 0;
  int          compares = 0;

  scm_top scm_top_i (
    .clock, .rst, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .sample_valid, .raw_temp, .raw_bridge_reading,
    .temp_gain, .temp_offset, .temp_second_order_coef,
    .bridge_gain, .bridge_offset, .bridge_nonlinearity_coef,
    .offset_drift, .gain_drift, .temp_corrected, .bridge_corrected,
    .drift_signs, .result_valid
  );

  // 40 ns period
  always #20 clock = ~clock;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // strobe held for exactly one rising edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clock);
    cfg_wr = 1'b0;
  endtask

  // read data is registered, so look one edge after the address
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clock);
    cfg_addr = a;
    @(negedge clock);
    chk(cfg_rdata, exp);
  endtask

  // one conversion; busy adds a second strobe that must be ignored
  task automatic conv(input logic [13:0] tr, input logic [15:0] tg, to, ts,
                      input logic [13:0] br, input logic [15:0] bg, bo, bs,
                      input logic [15:0] et, eb, input logic busy);
    @(negedge clock);
    {raw_temp, temp_gain, temp_offset, temp_second_order_coef} = {tr, tg, to, ts};
    {raw_bridge_reading, bridge_gain, bridge_offset} = {br, bg, bo};
    bridge_nonlinearity_coef = bs;
    sample_valid = 1'b1;
    // watch past the point where a wrongly taken second strobe would answer
    for (int k = 1; k <= SCM_LATENCY + 4; k++) begin
      @(negedge clock);
      sample_valid = busy && (k == 2);
      chk({15'h0000, result_valid}, 16'(k == SCM_LATENCY + 1));
      if (k == SCM_LATENCY + 1) begin
        chk(temp_corrected, et);
        chk(bridge_corrected, eb);
      end
    end
  endtask

  // run time is about 113 cycles (about 4.5 us); this is generous
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    chk(temp_corrected, 16'h0000);
    chk({14'h0000, drift_signs}, 16'h0000);
    rd(SCM_OFS_SIGN_CFG, 16'h0000);
    // preamp 24 with nulling on, switched ground on, half-range converter offset
    wr(SCM_OFS_BRIDGE_CFG, 16'h0aa8);
    wr(SCM_OFS_TEMP_CFG, 16'h1490);
    rd(SCM_OFS_BRIDGE_CFG, 16'h0aa8);
    rd(SCM_OFS_TEMP_CFG, 16'h1490);
    rd(5'h1f, 16'h0000);
    wr(SCM_OFS_SIGN_CFG, 16'h0c00);
    rd(SCM_OFS_SIGN_CFG, 16'h0c00);
    chk({14'h0000, drift_signs}, 16'h0003);
    wr(SCM_OFS_SIGN_CFG, 16'h0400);
    // drift signs are a registered copy, one edge behind the word
    @(negedge clock);
    chk({14'h0000, drift_signs}, 16'h0001);
    // offset -4, raw bridge -100 signed plus unsigned bias
    conv(14'h03e8, 16'h2000, 16'hfffc, 16'h0, 14'h3f9c, 16'h2000, 16'h0, 16'h0,
         16'h03e4, 16'h1f9c, 1'b0);
    // full-scale unsigned temperature, most negative bridge reading
    conv(14'h3fff, 16'h2000, 16'h0, 16'h0, 14'h2000, 16'h2000, 16'h0, 16'h0,
         16'h3fff, 16'h0000, 1'b0);
    // gain two, plain and as a times-eight code, then unity as a times-eight code
    conv(14'h0064, 16'h4000, 16'h0010, 16'h0, 14'h3f9c, 16'h8800, 16'h0, 16'h0,
         16'h00e8, 16'h1f38, 1'b0);
    conv(14'h01f4, 16'h8400, 16'h0, 16'h0, 14'h3f9c, 16'h2000, 16'h0064, 16'h0,
         16'h01f4, 16'h2000, 1'b0);
    wr(SCM_OFS_SIGN_CFG, 16'h0000);
    // positive second-order terms, z of 256 after the bias
    conv(14'h0100, 16'h2000, 16'h0, 16'h4000, 14'h2100, 16'h2000, 16'h0, 16'h4000,
         16'h8100, 16'h8100, 1'b0);
    wr(SCM_OFS_SIGN_CFG, 16'h3000);
    conv(14'h0100, 16'h2000, 16'h0, 16'h0200, 14'h2100, 16'h2000, 16'h0, 16'h0200,
         16'hfd00, 16'hfd00, 1'b0);
    // bridge sign must not leak into the temperature term
    wr(SCM_OFS_SIGN_CFG, 16'h2000);
    conv(14'h0100, 16'h2000, 16'h0, 16'h0200, 14'h2100, 16'h2000, 16'h0, 16'h0200,
         16'h0500, 16'hfd00, 1'b0);
    // s-shape: bridge loses bias and square term, temperature stays parabolic
    wr(SCM_OFS_SIGN_CFG, 16'h0200);
    rd(SCM_OFS_SIGN_CFG, 16'h0200);
    conv(14'h0100, 16'h2000, 16'h0, 16'h4000, 14'h2100, 16'h2000, 16'h0, 16'h4000,
         16'h8100, 16'he100, 1'b0);
    // a strobe while busy is dropped: one pulse, first result
    conv(14'h03e8, 16'h2000, 16'hfffc, 16'h0, 14'h3f9c, 16'h2000, 16'h0, 16'h0,
         16'h03e4, 16'hff9c, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
